/* File: uafc_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "uafc_consts.vh"

module uafc_fifo #(
    parameter WIDTH = `UAFC_DATA_W,
    parameter DEPTH = `UAFC_FIFO_DEPTH,
    parameter AW = 4
) (
    input wire clk_i,
    input wire rst_i,
    input wire flush_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] cnt_r;
    reg [AW:0] cnt_nxt;
    reg full_r;
    reg out_valid_r;
    reg [WIDTH-1:0] out_data_r;
    wire push;
    wire load;
    // The output word is held in a register so that consumers see flop outputs.
    assign push = in_valid_i && !full_r;
    assign load = (cnt_r != {(AW+1){1'b0}}) && (!out_valid_r || out_ready_i);
    assign in_ready_o = !full_r;
    assign out_valid_o = out_valid_r;
    assign out_data_o = out_data_r;
    always @* begin
        cnt_nxt = cnt_r;
        if (push && !load) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (load && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end
    always @(posedge clk_i) begin
        if (rst_i || flush_i) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
            full_r <= 1'b0;
            out_valid_r <= 1'b0;
            out_data_r <= {WIDTH{1'b0}};
        end else begin
            cnt_r <= cnt_nxt;
            full_r <= (cnt_nxt == DEPTH[AW:0]);
            if (push) begin
                mem_r[wr_ptr_r] <= in_data_i;
                wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
            end
            if (load) begin
                out_data_r <= mem_r[rd_ptr_r];
                out_valid_r <= 1'b1;
                rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
            end else if (out_ready_i) begin
                out_valid_r <= 1'b0;
            end
        end
    end
endmodule // uafc_fifo

module uafc_top #(
    parameter DEPTH = `UAFC_FIFO_DEPTH,
    parameter AW = 4
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [`UAFC_ADR_W-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    input wire address_detect_enable_i,
    input wire auto_match_enable_i,
    input wire rx_valid_i,
    input wire rx_is_addr_i,
    input wire [7:0] rx_data_i,
    output wire rx_ready_o,
    output wire tx_valid_o,
    input wire tx_ready_i,
    output wire [7:0] tx_data_o,
    output wire addr_match_o,
    output wire tx_dma_req_o,
    output wire rx_dma_req_o
);
    reg [7:0] match_address_r;
    reg tx_fifo_enable_r;
    reg rx_fifo_enable_r;
    reg tx_dma_request_enable_r;
    reg rx_dma_request_enable_r;
    reg flush_tx_r;
    reg flush_rx_r;
    reg ack_r;
    reg [31:0] dat_r;
    reg [31:0] dat_nxt;
    reg addr_match_r;
    reg tx_dma_r;
    reg rx_dma_r;
    reg rx_gate_r;
    wire req;
    wire wr;
    wire rd;
    wire tx_push;
    wire tx_full_n;
    wire rx_empty_n;
    wire [7:0] rx_word;
    wire rx_pop;
    wire rx_in_valid;
    wire rx_ready_int;
    wire match_mode;
    wire addr_hit;
    wire rx_take;
    reg [31:0] cfg_view;

    // One decoder serves the write strobes and the RX pop strobe; read data is selected by a separate case.
    function at_offset;
        input [`UAFC_ADR_W-1:0] adr;
        input [`UAFC_ADR_W-1:0] off;
        begin
            at_offset = (adr == off);
        end
    endfunction

    assign req = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr = req && wb_we_i;
    assign rd = req && !wb_we_i;
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign tx_push = wr && wb_sel_i[0] && at_offset(wb_adr_i, `UAFC_OFF_TX_DATA);
    assign rx_pop = rd && at_offset(wb_adr_i, `UAFC_OFF_RX_DATA);

    // Address characters are only filtered when both enables are set.
    assign match_mode = address_detect_enable_i && auto_match_enable_i;
    assign addr_hit = (rx_data_i == match_address_r);
    // Mismatched address characters are consumed and dropped; data after a
    // mismatch is dropped until the next matching address arrives.
    // Ready follows FIFO room even for characters that will be dropped; this
    // keeps it a plain flop output at the cost of stalling on a full FIFO.
    assign rx_take = rx_valid_i && rx_ready_int;
    assign rx_in_valid = rx_valid_i && (rx_is_addr_i ? (!match_mode || addr_hit) : rx_gate_r);
    assign rx_ready_o = rx_ready_int;

    // Bits outside the documented fields read as zero.
    always @* begin
        cfg_view = 32'h00000000;
        cfg_view[`UAFC_CFG_TXEN_BIT] = tx_fifo_enable_r;
        cfg_view[`UAFC_CFG_RXEN_BIT] = rx_fifo_enable_r;
        cfg_view[`UAFC_CFG_SIZE_LO +: 2] = `UAFC_CFG_SIZE_VAL;
        cfg_view[`UAFC_CFG_TX_DMA_BIT] = tx_dma_request_enable_r;
        cfg_view[`UAFC_CFG_RX_DMA_BIT] = rx_dma_request_enable_r;
    end

    uafc_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_tx_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .flush_i(flush_tx_r || !tx_fifo_enable_r),
        .in_valid_i(tx_push && tx_fifo_enable_r),
        .in_ready_o(tx_full_n),
        .in_data_i(wb_dat_i[7:0]),
        .out_valid_o(tx_valid_o),
        .out_ready_i(tx_ready_i),
        .out_data_o(tx_data_o)
    );

    uafc_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_rx_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .flush_i(flush_rx_r || !rx_fifo_enable_r),
        .in_valid_i(rx_in_valid && rx_fifo_enable_r),
        .in_ready_o(rx_ready_int),
        .in_data_i(rx_data_i),
        .out_valid_o(rx_empty_n),
        .out_ready_i(rx_pop),
        .out_data_o(rx_word)
    );

    always @* begin
        case (wb_adr_i)
            `UAFC_OFF_MATCH_ADDR: dat_nxt = {24'h000000, match_address_r};
            `UAFC_OFF_FIFO_CFG: dat_nxt = cfg_view;
            `UAFC_OFF_STATUS: dat_nxt = {28'h0000000, rx_empty_n, !tx_full_n, 2'h0};
            `UAFC_OFF_RX_DATA: dat_nxt = {23'h000000, !rx_empty_n, rx_word};
            default: dat_nxt = 32'h00000000;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h00000000;
            match_address_r <= `UAFC_MATCH_ADDR_RST;
            tx_fifo_enable_r <= 1'b0;
            rx_fifo_enable_r <= 1'b0;
            tx_dma_request_enable_r <= 1'b0;
            rx_dma_request_enable_r <= 1'b0;
            flush_tx_r <= 1'b0;
            flush_rx_r <= 1'b0;
            addr_match_r <= 1'b0;
            tx_dma_r <= 1'b0;
            rx_dma_r <= 1'b0;
            rx_gate_r <= 1'b1;
        end else begin
            ack_r <= req;
            dat_r <= rd ? dat_nxt : 32'h00000000;
            flush_tx_r <= 1'b0;
            flush_rx_r <= 1'b0;
            if (wr && at_offset(wb_adr_i, `UAFC_OFF_MATCH_ADDR) && wb_sel_i[0]) begin
                match_address_r <= wb_dat_i[7:0];
            end
            if (wr && at_offset(wb_adr_i, `UAFC_OFF_FIFO_CFG)) begin
                if (wb_sel_i[0]) begin
                    tx_fifo_enable_r <= wb_dat_i[`UAFC_CFG_TXEN_BIT];
                    rx_fifo_enable_r <= wb_dat_i[`UAFC_CFG_RXEN_BIT];
                end
                if (wb_sel_i[1]) begin
                    tx_dma_request_enable_r <= wb_dat_i[`UAFC_CFG_TX_DMA_BIT];
                    rx_dma_request_enable_r <= wb_dat_i[`UAFC_CFG_RX_DMA_BIT];
                end
                if (wb_sel_i[2]) begin
                    flush_tx_r <= wb_dat_i[`UAFC_CFG_FLUSHTX_BIT];
                    flush_rx_r <= wb_dat_i[`UAFC_CFG_FLUSHRX_BIT];
                end
            end
            if (rx_take && rx_is_addr_i) begin
                rx_gate_r <= !match_mode || addr_hit;
            end
            addr_match_r <= rx_take && rx_is_addr_i && match_mode && addr_hit;
            // Requests lag the FIFO state by one cycle, so a DMA engine must
            // tolerate one surplus request after the last slot is taken.
            tx_dma_r <= tx_dma_request_enable_r && tx_fifo_enable_r && tx_full_n;
            rx_dma_r <= rx_dma_request_enable_r && rx_empty_n;
        end
    end

    assign addr_match_o = addr_match_r;
    assign tx_dma_req_o = tx_dma_r;
    assign rx_dma_req_o = rx_dma_r;
endmodule // uafc_top
`default_nettype wire

/* File: uafc_consts.vh */
`ifndef UAFC_CONSTS_VH
`define UAFC_CONSTS_VH
`define UAFC_ADR_W 12
`define UAFC_OFF_MATCH_ADDR 12'h02C
`define UAFC_OFF_FIFO_CFG 12'hE00
`define UAFC_OFF_TX_DATA 12'hE20
`define UAFC_OFF_RX_DATA 12'hE30
`define UAFC_OFF_STATUS 12'hE04
`define UAFC_MATCH_ADDR_RST 8'h00
`define UAFC_CFG_TXEN_BIT 0
`define UAFC_CFG_RXEN_BIT 1
`define UAFC_CFG_SIZE_LO 4
`define UAFC_CFG_SIZE_VAL 2'h0
`define UAFC_CFG_TX_DMA_BIT 12
`define UAFC_CFG_RX_DMA_BIT 13
`define UAFC_CFG_FLUSHTX_BIT 16
`define UAFC_CFG_FLUSHRX_BIT 17
`define UAFC_FIFO_DEPTH 16
`define UAFC_DATA_W 8
`endif

/* File: uafc_top_props.sv */
`timescale 1ns/1ps
`default_nettype none
module uafc_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic address_detect_enable_i,
    input wire logic auto_match_enable_i,
    input wire logic rx_valid_i,
    input wire logic rx_is_addr_i,
    input wire logic rx_ready_o,
    input wire logic tx_valid_o,
    input wire logic tx_ready_i,
    input wire logic [7:0] tx_data_o,
    input wire logic addr_match_o,
    input wire logic tx_dma_req_o,
    input wire logic rx_dma_req_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire cfg_take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 12'hE00;
    sequence wb_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    ack_time_a: assert property (wb_take |=> ack_once) else $error("ack timing");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat not idle");
    reset_quiet_a: assert property ($past(rst_i) |-> !tx_dma_req_o && !rx_dma_req_o)
        else $error("request after reset");
    match_off_a: assert property ($past(!(address_detect_enable_i && auto_match_enable_i))
        |-> !addr_match_o) else $error("match while off");
    match_cause_a: assert property (addr_match_o |->
        $past(rx_valid_i && rx_ready_o && rx_is_addr_i)) else $error("match without address");
    tx_hold_a: assert property (tx_valid_o && !tx_ready_i && !$past(cfg_take) |=>
        tx_valid_o && $stable(tx_data_o)) else $error("tx word lost");
    tx_off_a: assert property ($past(cfg_take && wb_sel_i[0] && !wb_dat_i[0]) |=>
        !tx_valid_o) else $error("tx word after disable");
endmodule // uafc_chk
bind uafc_top uafc_chk uafc_chk_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .address_detect_enable_i, .auto_match_enable_i, .rx_valid_i, .rx_is_addr_i,
    .rx_ready_o, .tx_valid_o, .tx_ready_i, .tx_data_o, .addr_match_o, .tx_dma_req_o,
    .rx_dma_req_o);
`default_nettype wire

/* File: uafc_sink.sv */
`timescale 1ns/1ps
`default_nettype none
module uafc_sink (
    input wire logic clk_i,
    input wire logic stall_i,
    output var logic ready_o
);
    // Ready moves only after an edge, so a stall is seen as a real consumer would show it.
    initial ready_o = 1'h0;
    always @(posedge clk_i) ready_o <= !stall_i;
endmodule // uafc_sink
`default_nettype wire

/* File: tb_uart_fifo_config_addr_match.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_uart_fifo_config_addr_match;
    localparam int D = 16;
    logic clk_i = '0, rst_i = 1'h1, wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0, stall = 1'h1;
    logic [11:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = '0, wb_dat_o, q;
    logic wb_ack_o, address_detect_enable_i = '0, auto_match_enable_i = '0, rx_valid_i = '0;
    logic rx_is_addr_i = '0, rx_ready_o, tx_valid_o, tx_ready_i, addr_match_o;
    logic [7:0] rx_data_i = '0, tx_data_o, got[$];
    logic tx_dma_req_o, rx_dma_req_o;
    wire [1:0] hs = {rx_ready_o, wb_ack_o};
    int mismatches = 0, n_compared = 0;
    always #12.5 clk_i = ~clk_i;
    uafc_top uafc_top_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .address_detect_enable_i,
        .auto_match_enable_i, .rx_valid_i, .rx_is_addr_i, .rx_data_i, .rx_ready_o,
        .tx_valid_o, .tx_ready_i, .tx_data_o, .addr_match_o, .tx_dma_req_o, .rx_dma_req_o);
    uafc_sink uafc_sink_inst (.clk_i, .stall_i(stall), .ready_o(tx_ready_i));
    always @(posedge clk_i) if (tx_valid_o === 1'h1 && tx_ready_i === 1'h1) got.push_back(tx_data_o);
    task chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task waitfor(input int k);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (hs[k] !== 1'h1 && n < 50);
        if (n >= 50) begin
            mismatches++;
            tally_and_finish;
        end
    endtask
    // Covers the one-cycle request update plus the two-cycle data pipeline.
    task pause;
        repeat (3) @(posedge clk_i);
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
        waitfor(0);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask
    task rd_chk(input string nm, input logic [11:0] a, input logic [31:0] m, e);
        bus(1'h0, a, '0);
        chk(nm, e, q & m);
    endtask
    task send(input logic ad, input logic [7:0] d, input logic hit);
        @(posedge clk_i);
        {rx_valid_i, rx_is_addr_i, rx_data_i} <= {1'h1, ad, d};
        waitfor(1);
        rx_valid_i <= '0;
        @(posedge clk_i);
        chk("match pulse", hit, addr_match_o);
    endtask
    task t_regs;
        rd_chk("match rst", 12'h02C, 32'hFF, 32'h0);
        rd_chk("cfg rst", 12'hE00, 32'h3033, 32'h0);
        bus(1'h1, 12'hE00, 32'h1031);
        rd_chk("cfg", 12'hE00, 32'h3033, 32'h1001);
        rd_chk("unmapped", 12'h100, 32'hFFFFFFFF, 32'h0);
    endtask
    task t_tx;
        for (int i = 0; i <= D + 1; i++) begin
            if (i == D) chk("txreq room", 1, tx_dma_req_o);
            bus(1'h1, 12'hE20, i);
        end
        pause;
        chk("txreq full", 0, tx_dma_req_o);
        stall <= '0;
        for (int n = 0; n < 99 && got.size() < D + 1; n++) @(posedge clk_i);
        if (got.size() < D + 1) begin
            mismatches++;
            tally_and_finish;
        end
        pause;
        chk("tx count", D + 1, got.size());
        foreach (got[i]) chk("tx data", i, got[i]);
        chk("txreq drained", 1, tx_dma_req_o);
        bus(1'h1, 12'hE00, 32'h1);
        pause;
        chk("txreq off", 0, tx_dma_req_o);
    endtask
    task t_rx;
        bus(1'h1, 12'hE00, 32'h2);
        send(1'h0, 8'h44, 1'h0);
        pause;
        chk("rxreq off", 0, rx_dma_req_o);
        bus(1'h1, 12'hE00, 32'h2002);
        pause;
        chk("rxreq on", 1, rx_dma_req_o);
        rd_chk("rx data", 12'hE30, 32'h1FF, 32'h44);
        pause;
        chk("rxreq empty", 0, rx_dma_req_o);
        bus(1'h1, 12'h02C, 32'h5A);
        rd_chk("match", 12'h02C, 32'hFF, 32'h5A);
        {address_detect_enable_i, auto_match_enable_i} <= 2'h3;
        send(1'h1, 8'h33, 1'h0);
        send(1'h0, 8'h11, 1'h0);
        send(1'h1, 8'h5A, 1'h1);
        send(1'h0, 8'h22, 1'h0);
        pause;
        rd_chk("rx addr", 12'hE30, 32'h1FF, 32'h5A);
        rd_chk("rx after", 12'hE30, 32'h1FF, 32'h22);
        rd_chk("rx empty", 12'hE30, 32'h100, 32'h100);
    endtask
    task t_flush;
        stall <= 1'h1;
        bus(1'h1, 12'hE20, 32'h77);
        bus(1'h1, 12'hE00, 32'h3);
        pause;
        chk("tx off drop", 0, tx_valid_o);
        bus(1'h1, 12'hE20, 32'hA5);
        pause;
        chk("tx on word", 32'h1A5, {tx_valid_o, tx_data_o});
        rd_chk("status", 12'hE04, 32'hC, 32'h0);
        bus(1'h1, 12'hE00, 32'h10003);
        pause;
        chk("tx flushed", 0, tx_valid_o);
        send(1'h0, 8'h66, 1'h0);
        rd_chk("status rx", 12'hE04, 32'hC, 32'h8);
        bus(1'h1, 12'hE00, 32'h20003);
        rd_chk("rx flushed", 12'hE30, 32'h100, 32'h100);
        stall <= 1'h0;
        pause;
        chk("tx total", D + 1, got.size());
    endtask
    task tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= '0;
        t_regs;
        t_tx;
        t_rx;
        t_flush;
        tally_and_finish;
    end
endmodule // tb_uart_fifo_config_addr_match
`default_nettype wire
